// file: src/fpc_consts.vh
`ifndef FPC_CONSTS_VH
`define FPC_CONSTS_VH
// ****************************************
// Timing
// ****************************************
`define FPC_CLK_HZ 20000000
`define FPC_MAX_PER_S 25
`define FPC_MAX_PER_CYC (`FPC_MAX_PER_S * `FPC_CLK_HZ)
`define FPC_UPD_MS 10
`define FPC_UPD_CYC (`FPC_UPD_MS * (`FPC_CLK_HZ / 1000))
// ****************************************
// Register offsets
// ****************************************
`define FPC_ADR_SLOT_A 8'h00
`define FPC_ADR_SLOT_B 8'h04
`define FPC_ADR_SELECT 8'h08
`define FPC_ADR_CTRL 8'h0C
`define FPC_ADR_UPD 8'h10
`define FPC_ADR_VEL_TB 8'h14
`define FPC_ADR_INCR 8'h18
`define FPC_ADR_COUNT 8'h1C
`define FPC_ADR_MEAS 8'h20
`define FPC_ADR_STATUS 8'h24
// ****************************************
// Control fields and selector codes
// ****************************************
`define FPC_C_SWGATE 0
`define FPC_C_HWGATE 1
`define FPC_C_MODE 3:2
`define FPC_C_SYSRC 5:4
`define FPC_C_SYFALL 6
`define FPC_C_SYEN 7
`define FPC_C_CMP 9:8
`define FPC_C_HWEN 13:10
`define FPC_C_DGEN 16:14
`define FPC_MODE_FREQ 2'h0
`define FPC_MODE_PER 2'h1
`define FPC_MODE_VEL 2'h2
`define FPC_SEL_IDLE 4'h0
`define FPC_SEL_CNT 4'h1
`define FPC_SEL_START 4'h3
`define FPC_SEL_CMP0 4'h4
`define FPC_SEL_CMP1 4'h5
`define FPC_SEL_LOW 4'h6
`define FPC_SEL_HIGH 4'h7
`define FPC_LOW_RST 32'h80000000
`define FPC_HIGH_RST 32'h7FFFFFFF
`define FPC_FLT_BIAS 8'h7F
`endif

// file: src/fpc_measure.v
// The Wishbone slave port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "fpc_consts.vh"
module fpc_measure #(
  parameter [31:0] MAX_PER_CYC = `FPC_MAX_PER_CYC,
  parameter [31:0] UPD_RST = `FPC_UPD_CYC
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire enc_a_i,
  input wire enc_b_i,
  input wire enc_n_i,
  input wire sync_din_i,
  input wire gate_din_i,
  input wire enc_supply_ok_i,
  input wire hw_irq_ack_i,
  input wire diag_irq_ack_i,
  output reg compare_output_b_o,
  output reg hw_irq_o,
  output reg diag_irq_o
);
  localparam [3:0] S_IDLE = 4'b0001;
  localparam [3:0] S_NORM = 4'b0010;
  localparam [3:0] S_DIV = 4'b0100;
  localparam [3:0] S_PACK = 4'b1000;
  localparam [63:0] CLK_HZ = {32'h00000000, 32'd`FPC_CLK_HZ};

  function [31:0] fpc_merge;
    input [31:0] old;
    input [31:0] dat;
    input [3:0] sel;
    integer k;
    begin
      fpc_merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (sel[k]) begin
          fpc_merge[k*8 +: 8] = dat[k*8 +: 8];
        end
      end
    end
  endfunction

  function [5:0] fpc_lz;
    input [63:0] x;
    reg [6:0] i;
    begin
      fpc_lz = 6'h00;
      for (i = 7'h00; i < 7'h40; i = i + 7'h01) begin
        if (x[i[5:0]]) begin
          fpc_lz = ~i[5:0];
        end
      end
    end
  endfunction

  // ****************************************
  // Register file
  // ****************************************
  reg [31:0] slot_a_ff, slot_b_ff, ctrl_ff, upd_int_ff, vel_tb_ff;
  reg [15:0] incr_ff;
  reg [3:0] pend_b_ff;
  reg signed [31:0] cnt_ff, start_ff, cmp0_ff, cmp1_ff, low_ff, high_ff;
  reg [31:0] meas_ff;
  reg [3:0] hw_cause_ff;
  reg [2:0] dg_cause_ff;
  reg dir_ff;
  wire acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = acc & wb_we_i;
  wire wr_sel = wr & (wb_adr_i == `FPC_ADR_SELECT) & wb_sel_i[0];
  reg [31:0] rd_val;
  wire [31:0] incr_mrg = fpc_merge({16'h0000, incr_ff}, wb_dat_i, wb_sel_i);
  wire gate_open = ctrl_ff[`FPC_C_SWGATE] & (~ctrl_ff[`FPC_C_HWGATE] | gate_din_i);

  always @* begin
    if (wb_adr_i == `FPC_ADR_CTRL) begin
      rd_val = ctrl_ff;
    end else if (wb_adr_i == `FPC_ADR_UPD) begin
      rd_val = upd_int_ff;
    end else if (wb_adr_i == `FPC_ADR_VEL_TB) begin
      rd_val = vel_tb_ff;
    end else if (wb_adr_i == `FPC_ADR_INCR) begin
      rd_val = {16'h0000, incr_ff};
    end else if (wb_adr_i == `FPC_ADR_COUNT) begin
      rd_val = cnt_ff;
    end else if (wb_adr_i == `FPC_ADR_MEAS) begin
      rd_val = meas_ff;
    end else if (wb_adr_i == `FPC_ADR_STATUS) begin
      rd_val = {23'h000000, gate_open, dir_ff, dg_cause_ff, hw_cause_ff};
    end else begin
      rd_val = 32'h00000000;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      slot_a_ff <= 32'h00000000;
      slot_b_ff <= 32'h00000000;
      ctrl_ff <= 32'h00000000;
      upd_int_ff <= UPD_RST;
      vel_tb_ff <= 32'h00000001;
      incr_ff <= 16'h0001;
    end else begin
      wb_ack_o <= acc;
      wb_dat_o <= (acc & ~wb_we_i) ? rd_val : 32'h00000000;
      if (wr) begin
        if (wb_adr_i == `FPC_ADR_SLOT_A) begin
          slot_a_ff <= fpc_merge(slot_a_ff, wb_dat_i, wb_sel_i);
        end else if (wb_adr_i == `FPC_ADR_SLOT_B) begin
          slot_b_ff <= fpc_merge(slot_b_ff, wb_dat_i, wb_sel_i);
        end else if (wb_adr_i == `FPC_ADR_CTRL) begin
          ctrl_ff <= fpc_merge(ctrl_ff, wb_dat_i, wb_sel_i);
        end else if (wb_adr_i == `FPC_ADR_UPD) begin
          upd_int_ff <= fpc_merge(upd_int_ff, wb_dat_i, wb_sel_i);
        end else if (wb_adr_i == `FPC_ADR_VEL_TB) begin
          vel_tb_ff <= fpc_merge(vel_tb_ff, wb_dat_i, wb_sel_i);
        end else if (wb_adr_i == `FPC_ADR_INCR) begin
          incr_ff <= incr_mrg[15:0];
        end
      end
    end
  end

  // ****************************************
  // Slot loads
  // ****************************************
  // Slot A acts in the write cycle, slot B one cycle later
  wire [3:0] act_code = wr_sel ? wb_dat_i[3:0] : pend_b_ff;
  wire [31:0] act_val = wr_sel ? slot_a_ff : slot_b_ff;
  wire ld_cnt = (act_code == `FPC_SEL_CNT);

  always @(posedge clk_i) begin
    if (rst_i) begin
      pend_b_ff <= `FPC_SEL_IDLE;
      start_ff <= 32'h00000000;
      cmp0_ff <= 32'h00000000;
      cmp1_ff <= 32'h00000000;
      low_ff <= `FPC_LOW_RST;
      high_ff <= `FPC_HIGH_RST;
    end else begin
      pend_b_ff <= wr_sel ? wb_dat_i[7:4] : `FPC_SEL_IDLE;
      if (act_code == `FPC_SEL_START) begin
        start_ff <= act_val;
      end
      if (act_code == `FPC_SEL_CMP0) begin
        cmp0_ff <= act_val;
      end
      if (act_code == `FPC_SEL_CMP1) begin
        cmp1_ff <= act_val;
      end
      if (act_code == `FPC_SEL_LOW) begin
        low_ff <= act_val;
      end
      if (act_code == `FPC_SEL_HIGH) begin
        high_ff <= act_val;
      end
    end
  end

  // ****************************************
  // Encoder decode and counter
  // ****************************************
  reg a_q, b_q, n_q, din_q, sup_q, cmp_hit_ff;
  wire a_chg = a_q ^ enc_a_i;
  wire b_chg = b_q ^ enc_b_i;
  // Fourfold evaluation: each A or B edge on one track alone is one step while the gate is open
  wire step = (a_chg ^ b_chg) & gate_open;
  wire up = a_q ^ enc_b_i;
  wire ab_err = a_chg & b_chg;
  wire n_rise = enc_n_i & ~n_q;
  wire din_edge = ctrl_ff[`FPC_C_SYFALL] ? (din_q & ~sync_din_i) : (~din_q & sync_din_i);
  reg sync_src;
  always @* begin
    case (ctrl_ff[`FPC_C_SYSRC])
      2'h0: sync_src = din_edge;
      2'h1: sync_src = n_rise;
      2'h2: sync_src = n_rise & sync_din_i;
      default: sync_src = 1'b0;
    endcase
  end
  wire sync_hit = ctrl_ff[`FPC_C_SYEN] & sync_src;

  reg signed [31:0] nxt_cnt;
  reg ovf, unf;
  always @* begin
    nxt_cnt = cnt_ff;
    ovf = 1'b0;
    unf = 1'b0;
    if (ld_cnt) begin
      nxt_cnt = act_val;
    end else if (sync_hit) begin
      nxt_cnt = start_ff;
    end else if (step & up) begin
      if (cnt_ff == high_ff) begin
        nxt_cnt = low_ff;
        ovf = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + 32'sh00000001;
      end
    end else if (step) begin
      if (cnt_ff == low_ff) begin
        nxt_cnt = high_ff;
        unf = 1'b1;
      end else begin
        nxt_cnt = cnt_ff - 32'sh00000001;
      end
    end
  end

  reg [1:0] cmp_mode_dummy;
  reg cmp_hit;
  always @* begin
    cmp_mode_dummy = ctrl_ff[`FPC_C_CMP];
    case (cmp_mode_dummy)
      2'h1: cmp_hit = (cnt_ff >= cmp0_ff) & (cnt_ff <= cmp1_ff);
      2'h2: cmp_hit = (cnt_ff >= cmp0_ff);
      2'h3: cmp_hit = (cnt_ff <= cmp1_ff);
      default: cmp_hit = 1'b0;
    endcase
  end

  wire zero_x = step & (nxt_cnt == 32'sh00000000) & (cnt_ff != 32'sh00000000);
  wire dir_rev = step & (up != dir_ff);
  wire [3:0] hw_ev = {dir_rev, zero_x, ovf | unf, cmp_hit & ~cmp_hit_ff}
                     & ctrl_ff[`FPC_C_HWEN];
  wire lost = (|hw_ev) & hw_irq_o & ~hw_irq_ack_i;
  wire [2:0] dg_ev = {lost, ab_err, sup_q & ~enc_supply_ok_i}
                     & ctrl_ff[`FPC_C_DGEN];

  always @(posedge clk_i) begin
    if (rst_i) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
      n_q <= 1'b0;
      din_q <= 1'b0;
      sup_q <= 1'b1;
      cnt_ff <= 32'h00000000;
      dir_ff <= 1'b1;
      cmp_hit_ff <= 1'b0;
      compare_output_b_o <= 1'b0;
      hw_irq_o <= 1'b0;
      diag_irq_o <= 1'b0;
      hw_cause_ff <= 4'h0;
      dg_cause_ff <= 3'h0;
    end else begin
      a_q <= enc_a_i;
      b_q <= enc_b_i;
      n_q <= enc_n_i;
      din_q <= sync_din_i;
      sup_q <= enc_supply_ok_i;
      cnt_ff <= nxt_cnt;
      if (step) begin
        dir_ff <= up;
      end
      cmp_hit_ff <= cmp_hit;
      compare_output_b_o <= cmp_hit;
      // New event beats a simultaneous acknowledge
      hw_irq_o <= (|hw_ev) | (hw_irq_o & ~hw_irq_ack_i);
      hw_cause_ff <= hw_ev | (hw_irq_ack_i ? 4'h0 : hw_cause_ff);
      diag_irq_o <= (|dg_ev) | (diag_irq_o & ~diag_irq_ack_i);
      dg_cause_ff <= dg_ev | (diag_irq_ack_i ? 3'h0 : dg_cause_ff);
    end
  end

  // ****************************************
  // Measurement timing
  // ****************************************
  reg [31:0] ts_ff, upd_cnt_ff, ref_ts_ff, last_ts_ff;
  reg signed [31:0] pos_ff, ref_pos_ff, last_pos_ff;
  reg ref_ok_ff, new_ff, gate_q;
  reg [3:0] st_ff;
  wire tick = (upd_cnt_ff == 32'h00000000);
  // Reload one less, so a tick comes every upd_int_ff cycles
  wire [31:0] upd_rld = upd_int_ff - 32'h00000001;
  wire [31:0] dt = last_ts_ff - ref_ts_ff;
  wire signed [31:0] dn = last_pos_ff - ref_pos_ff;
  wire [31:0] adn = dn[31] ? (32'h00000000 - dn) : dn;
  // Gate closed: no new division starts, meas_ff holds its value
  wire start_div = tick & gate_open & ref_ok_ff & new_ff & st_ff[0];
  // Pulses too slow for the longest period: report zero instead of stale value
  wire stale = tick & gate_open & ref_ok_ff & ~new_ff
               & ((ts_ff - ref_ts_ff) > MAX_PER_CYC);

  always @(posedge clk_i) begin
    if (rst_i) begin
      ts_ff <= 32'h00000000;
      upd_cnt_ff <= UPD_RST - 32'h00000001;
      pos_ff <= 32'h00000000;
      ref_ts_ff <= 32'h00000000;
      ref_pos_ff <= 32'h00000000;
      last_ts_ff <= 32'h00000000;
      last_pos_ff <= 32'h00000000;
      ref_ok_ff <= 1'b0;
      new_ff <= 1'b0;
      gate_q <= 1'b0;
    end else begin
      ts_ff <= ts_ff + 32'h00000001;
      upd_cnt_ff <= tick ? upd_rld : upd_cnt_ff - 32'h00000001;
      gate_q <= gate_open;
      if (step) begin
        pos_ff <= up ? pos_ff + 32'sh00000001 : pos_ff - 32'sh00000001;
      end
      if (~gate_open | ~gate_q) begin
        ref_ok_ff <= 1'b0;
        new_ff <= 1'b0;
      end else if (step & ~ref_ok_ff) begin
        ref_ts_ff <= ts_ff;
        ref_pos_ff <= up ? pos_ff + 32'sh00000001 : pos_ff - 32'sh00000001;
        ref_ok_ff <= 1'b1;
      end else begin
        if (step) begin
          last_ts_ff <= ts_ff;
          last_pos_ff <= up ? pos_ff + 32'sh00000001 : pos_ff - 32'sh00000001;
        end
        if (start_div) begin
          ref_ts_ff <= last_ts_ff;
          ref_pos_ff <= last_pos_ff;
        end
        new_ff <= step | (new_ff & ~start_div);
      end
    end
  end

  // ****************************************
  // Float divider
  // ****************************************
  reg [63:0] num_ff, den_ff;
  reg [32:0] rem_ff;
  reg [31:0] dv_ff;
  reg [24:0] q_ff;
  reg [4:0] it_ff;
  reg signed [7:0] ex_ff;
  reg sgn_ff;
  reg [63:0] nxt_num, nxt_den;
  always @* begin
    case (ctrl_ff[`FPC_C_MODE])
      `FPC_MODE_PER: begin
        nxt_num = {32'h00000000, dt};
        nxt_den = {32'h00000000, adn} * CLK_HZ;
      end
      `FPC_MODE_VEL: begin
        nxt_num = {32'h00000000, adn} * {32'h00000000, vel_tb_ff};
        nxt_den = {32'h00000000, dt} * {48'h000000000000, incr_ff};
      end
      default: begin
        nxt_num = {32'h00000000, adn} * CLK_HZ;
        nxt_den = {32'h00000000, dt};
      end
    endcase
  end
  wire [5:0] lzn = fpc_lz(num_ff);
  wire [5:0] lzd = fpc_lz(den_ff);
  wire [63:0] nn = num_ff << lzn;
  wire [63:0] nd = den_ff << lzd;
  wire ge = (rem_ff >= {1'b0, dv_ff});
  wire [32:0] rsub = ge ? rem_ff - {1'b0, dv_ff} : rem_ff;
  wire signed [7:0] ex_adj = q_ff[24] ? ex_ff : ex_ff - 8'sh01;
  wire [22:0] man = q_ff[24] ? q_ff[23:1] : q_ff[22:0];

  always @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= S_IDLE;
      num_ff <= 64'h0000000000000000;
      den_ff <= 64'h0000000000000000;
      rem_ff <= 33'h000000000;
      dv_ff <= 32'h00000000;
      q_ff <= 25'h0000000;
      it_ff <= 5'h00;
      ex_ff <= 8'sh00;
      sgn_ff <= 1'b0;
      meas_ff <= 32'h00000000;
    end else begin
      case (st_ff)
        S_IDLE: begin
          if (start_div) begin
            num_ff <= nxt_num;
            den_ff <= nxt_den;
            sgn_ff <= dn[31];
            st_ff <= S_NORM;
          end else if (stale) begin
            meas_ff <= 32'h00000000;
          end
        end
        S_NORM: begin
          if ((num_ff == 64'h0000000000000000) | (den_ff == 64'h0000000000000000)) begin
            meas_ff <= 32'h00000000;
            st_ff <= S_IDLE;
          end else begin
            rem_ff <= {1'b0, nn[63:32]};
            dv_ff <= nd[63:32];
            ex_ff <= $signed({2'b00, lzd}) - $signed({2'b00, lzn});
            it_ff <= 5'h00;
            st_ff <= S_DIV;
          end
        end
        S_DIV: begin
          q_ff <= {q_ff[23:0], ge};
          rem_ff <= {rsub[31:0], 1'b0};
          it_ff <= it_ff + 5'h01;
          if (it_ff == 5'h18) begin
            st_ff <= S_PACK;
          end
        end
        S_PACK: begin
          // Truncated mantissa; one ulp low at worst
          meas_ff <= {sgn_ff, ex_adj + `FPC_FLT_BIAS, man};
          st_ff <= S_IDLE;
        end
        default: st_ff <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// file: test/fpc_measure_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module fpc_measure_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic hw_irq_ack_i,
  input wire logic diag_irq_ack_i,
  input wire logic compare_output_b_o,
  input wire logic hw_irq_o,
  input wire logic diag_irq_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_rd_wo;
    s_req ##0 (!wb_we_i && (wb_adr_i inside {8'h00, 8'h04, 8'h08}));
  endsequence
  sequence s_rd_far;
    s_req ##0 (!wb_we_i && wb_adr_i[7:6] != 2'h0);
  endsequence
  a_req_answer: assert property (s_req |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o))
    else $error("acknowledge without request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside acknowledge");
  a_wo_read_zero: assert property (s_rd_wo |=> wb_ack_o && wb_dat_o == 32'h0)
    else $error("load slot or selector reads nonzero");
  a_far_read_zero: assert property (s_rd_far |=> wb_dat_o == 32'h0)
    else $error("unmapped read nonzero");
  a_hw_irq_hold: assert property (hw_irq_o && !hw_irq_ack_i |=> hw_irq_o)
    else $error("hardware interrupt dropped without ack");
  a_diag_irq_hold: assert property (diag_irq_o && !diag_irq_ack_i |=> diag_irq_o)
    else $error("diagnostic interrupt dropped without ack");
  a_rst_quiet: assert property (disable iff (1'b0)
    rst_i |=> !wb_ack_o && !hw_irq_o && !diag_irq_o && !compare_output_b_o)
    else $error("outputs active after reset");
endmodule
`default_nettype wire

// file: test/fpc_enc_model.sv
`timescale 1ns/100ps
`default_nettype none
module fpc_enc_model (
  input wire logic clk_i,
  input wire logic step_i,
  input wire logic up_i,
  input wire logic bad_i,
  output var logic enc_a_o,
  output var logic enc_b_o
);
  initial begin
    enc_a_o = 1'b0;
    enc_b_o = 1'b0;
  end
  // Only one track moves per step, so every step edge is a count; bad_i flips both tracks
  always @(posedge clk_i) begin
    if (bad_i) begin
      enc_a_o <= ~enc_a_o;
      enc_b_o <= ~enc_b_o;
    end else if (step_i && up_i) begin
      enc_a_o <= enc_b_o;
      enc_b_o <= ~enc_a_o;
    end else if (step_i) begin
      enc_a_o <= ~enc_b_o;
      enc_b_o <= enc_a_o;
    end
  end
endmodule
`default_nettype wire

// file: test/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  typedef struct packed {logic [31:0] a; logic [31:0] b; logic [7:0] s; logic [31:0] c;} fpc_row_t;
  typedef struct packed {logic [31:0] ctl; logic dir; logic [31:0] val;} fpc_meas_t;
  localparam fpc_row_t ROWS[6] = '{
    '{32'h12345678, 32'h0, 8'h01, 32'h12345678},
    '{32'h5, 32'h9, 8'h11, 32'h9},
    '{32'hAA, 32'h0, 8'h02, 32'h9},
    '{32'hAB, 32'h0, 8'h08, 32'h9},
    '{32'hAC, 32'h77, 8'hF1, 32'hAC},
    '{32'h0, 32'h40, 8'h10, 32'h40}};
  localparam fpc_meas_t MEAS[4] = '{
    '{32'h1, 1'b1, 32'h49F42400}, '{32'h1, 1'b0, 32'hC9F42400},
    '{32'h5, 1'b1, 32'h350637BD}, '{32'h9, 1'b1, 32'h40000000}};
  localparam logic [31:0] SCTL[5] = '{32'h80, 32'hC0, 32'h90, 32'hA0, 32'hA0};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd, held;
  logic enc_a, enc_b, step = 1'b0, up = 1'b1, bad = 1'b0;
  logic enc_n_i = 1'b0, sync_din_i = 1'b0, gate_din_i = 1'b0, enc_supply_ok_i = 1'b1;
  logic hw_irq_ack_i = 1'b0, diag_irq_ack_i = 1'b0;
  logic compare_output_b_o, hw_irq_o, diag_irq_o;
  int fails = 0;
  int n_tests = 0;
  always #25 clk_i = ~clk_i;
  fpc_measure #(.MAX_PER_CYC(32'd2000), .UPD_RST(32'd100)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .enc_a_i(enc_a), .enc_b_i(enc_b), .enc_n_i(enc_n_i), .sync_din_i(sync_din_i),
    .gate_din_i(gate_din_i), .enc_supply_ok_i(enc_supply_ok_i), .hw_irq_ack_i(hw_irq_ack_i),
    .diag_irq_ack_i(diag_irq_ack_i), .compare_output_b_o(compare_output_b_o),
    .hw_irq_o(hw_irq_o), .diag_irq_o(diag_irq_o));
  fpc_enc_model enc (.clk_i(clk_i), .step_i(step), .up_i(up), .bad_i(bad),
    .enc_a_o(enc_a), .enc_b_o(enc_b));
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int i;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hF;
    wb_dat_i <= dat;
    for (i = 0; i < 20 && wb_ack_o !== 1'b1; i++) begin
      @(posedge clk_i);
      rd = wb_dat_o;
    end
    if (i == 20) begin
      fails++;
      $display("MISMATCH bus ack expected 1 seen %b", wb_ack_o);
      report_and_stop;
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic ld(input logic [31:0] a, input logic [31:0] b, input logic [7:0] s);
    wb(1'b1, 8'h00, a);
    wb(1'b1, 8'h04, b);
    wb(1'b1, 8'h08, {24'h0, s});
  endtask
  task automatic wait_for(input int k, input logic exp);
    logic [2:0] v;
    n_tests++;
    for (int i = 0; i < 400; i++) begin
      @(posedge clk_i);
      v = {diag_irq_o, hw_irq_o, compare_output_b_o};
      if (v[k] === exp) return;
    end
    fails++;
    $display("MISMATCH output %0d expected %b seen %b", k, exp, v[k]);
    report_and_stop;
  endtask
  task automatic steps(input int n, input logic dir);
    up <= dir;
    repeat (n) begin
      step <= 1'b1;
      @(posedge clk_i);
      step <= 1'b0;
      repeat (9) @(posedge clk_i);
    end
  endtask
  task automatic rd_chk(input string name, input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0);
    chk(name, exp, rd);
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd_chk("slot read", 8'h00, 32'h0);
    rd_chk("unmapped read", 8'h40, 32'h0);
    // Count readback proves the counter selector code, ignored codes 2, 8 and F, and slot ordering
    foreach (ROWS[r]) begin
      ld(ROWS[r].a, ROWS[r].b, ROWS[r].s);
      rd_chk("slot load", 8'h1C, ROWS[r].c);
    end
    ld(32'h33, 32'h41, 8'h76);
    wb(1'b1, 8'h10, 32'd100);
    wb(1'b1, 8'h0C, 32'h801);
    steps(2, 1'b1);
    rd_chk("wrap count", 8'h1C, 32'h33);
    wait_for(1, 1'b1);
    hw_irq_ack_i <= 1'b1;
    @(posedge clk_i);
    hw_irq_ack_i <= 1'b0;
    wait_for(1, 1'b0);
    wb(1'b1, 8'h14, 32'd20);
    foreach (MEAS[m]) begin
      wb(1'b1, 8'h0C, MEAS[m].ctl);
      steps(40, MEAS[m].dir);
      rd_chk("measured", 8'h20, MEAS[m].val);
    end
    wb(1'b1, 8'h0C, 32'h8);
    wb(1'b0, 8'h1C, 32'h0);
    held = rd;
    steps(10, 1'b1);
    repeat (300) @(posedge clk_i);
    rd_chk("held measured", 8'h20, 32'h40000000);
    rd_chk("closed count", 8'h1C, held);
    for (int k = 0; k < 5; k++) begin
      ld(32'h0, 32'h100 + k, 8'h31);
      sync_din_i <= (k == 1 || k == 3);
      wb(1'b1, 8'h0C, SCTL[k]);
      if (k < 2) sync_din_i <= (k == 0);
      else enc_n_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      enc_n_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      rd_chk("sync count", 8'h1C, (k == 4) ? 32'h0 : 32'h100 + k);
    end
    ld(32'h10, 32'h20, 8'h54);
    wb(1'b1, 8'h0C, 32'h100);
    ld(32'h15, 32'h0, 8'h01);
    wait_for(0, 1'b1);
    ld(32'h12, 32'h0, 8'h05);
    wait_for(0, 1'b0);
    wb(1'b1, 8'h0C, 32'h200);
    wait_for(0, 1'b1);
    wb(1'b1, 8'h0C, 32'h300);
    wait_for(0, 1'b0);
    wb(1'b1, 8'h0C, 32'hC000);
    for (int k = 0; k < 2; k++) begin
      if (k == 0) bad <= 1'b1;
      else enc_supply_ok_i <= 1'b0;
      @(posedge clk_i);
      bad <= 1'b0;
      wait_for(2, 1'b1);
      diag_irq_ack_i <= 1'b1;
      @(posedge clk_i);
      diag_irq_ack_i <= 1'b0;
      wait_for(2, 1'b0);
    end
    // Zero crossing with reversal, then a reversal while pending is lost
    ld(32'h1, 32'h0, 8'h01);
    wb(1'b1, 8'h0C, 32'h13001);
    steps(1, 1'b0);
    wait_for(1, 1'b1);
    rd_chk("status zero dir", 8'h24, 32'h10C);
    steps(1, 1'b1);
    wait_for(2, 1'b1);
    rd_chk("status lost", 8'h24, 32'h1CC);
    repeat (2200) @(posedge clk_i);
    rd_chk("stale measured", 8'h20, 32'h0);
    wb(1'b1, 8'h0C, 32'h13003);
    rd_chk("hw gate shut", 8'h24, 32'hCC);
    gate_din_i <= 1'b1;
    rd_chk("hw gate open", 8'h24, 32'h1CC);
    // Mid-run reset, first request at the first edge after release
    wb(1'b1, 8'h10, 32'd77);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk("reset ctrl", 8'h0C, 32'h0);
    rd_chk("reset count", 8'h1C, 32'h0);
    rd_chk("reset interval", 8'h10, 32'd100);
    chk("reset irq", 32'h0, {30'h0, diag_irq_o, hw_irq_o});
    report_and_stop;
  end
endmodule
bind fpc_measure fpc_measure_monitor mon (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .hw_irq_ack_i(hw_irq_ack_i), .diag_irq_ack_i(diag_irq_ack_i),
  .compare_output_b_o(compare_output_b_o), .hw_irq_o(hw_irq_o), .diag_irq_o(diag_irq_o));
`default_nettype wire
